// ===== logic/dci_device.sv
// What this block does
// - share the processor clock, same phase
// - request service by pulling interrupt line low
// - acknowledge is fetch strobe low, then io
// - chain head priority input tied high
// - pending or in-service drives priority out low
// - otherwise priority out follows priority in
// - status frozen while fetch strobe is low
// - granted requester drives vector, sets in-service
// - fixed internal chain ranks sources, allows nesting
// - return opcode pair snooped during fetches
// - first return byte unblocks unacknowledged pendings
// - second byte clears the highest-ranked in-service latch
// - chain length limited by ripple time
// - one writable vector, read back modified
module dci_device
  import dci_pkg::*;
#(
  parameter int NSRC = DCI_NSRC
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [NSRC-1:0] event_i,
  input wire logic vec_wr_i,
  input wire logic [7:0] vec_wdata_i,
  output logic [7:0] vec_rdata_o,
  output logic [NSRC-1:0] in_service_o,
  dci_if.dev bus
);
  localparam int IDX_W = (NSRC > 1) ? $clog2(NSRC) : 1;
  localparam logic [IDX_W-1:0] IDLE_CODE = '1;

  // index of the lowest set bit; source 0 ranks highest
  function automatic logic [IDX_W-1:0] dci_first_idx(input logic [NSRC-1:0] v);
    logic [IDX_W-1:0] idx;
    idx = IDLE_CODE;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction : dci_first_idx

  // vector with the source code folded into its low bits, just above bit 0
  function automatic logic [7:0] dci_mod_vec(input logic [7:0] v, input logic [IDX_W-1:0] c);
    logic [7:0] r;
    r = v;
    r[DCI_VEC_CODE_LSB +: IDX_W] = c;
    return r;
  endfunction : dci_mod_vec

  logic [NSRC-1:0] pending;
  logic [NSRC-1:0] next_pending;
  logic [NSRC-1:0] arrived;
  logic [NSRC-1:0] next_arrived;
  logic [NSRC-1:0] ius;
  logic [NSRC-1:0] next_ius;
  logic [7:0] vector;
  logic [7:0] next_vector;
  logic fetch_n_q;
  logic io_n_q;
  logic ack_cycle;
  logic next_ack_cycle;
  logic ed_seen;
  logic next_ed_seen;
  logic [7:0] fetch_byte;
  logic [7:0] next_fetch_byte;
  logic int_n;
  logic next_int_n;
  logic prio_out;
  logic next_prio_out;
  logic [7:0] dout;
  logic [7:0] next_dout;
  logic dout_oe;
  logic next_dout_oe;
  logic [7:0] vec_rd;
  logic [7:0] next_vec_rd;

  // chain terms, rebuilt each cycle from the latched status
  logic [NSRC-1:0] blocking;
  logic [NSRC:0] chain_in;
  logic [NSRC-1:0] higher_ius;
  logic [NSRC-1:0] may_request;
  logic [NSRC-1:0] grant;
  logic [NSRC-1:0] ret_clear;
  logic ack_edge;
  logic fetch_end;

  // internal daisy chain inside the external one
  always_comb begin
    blocking = ius | (pending & ~{NSRC{ed_seen}});
    chain_in[0] = bus.priority_in;
    higher_ius[0] = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      chain_in[i+1] = chain_in[i] & ~blocking[i];
      if (i > 0) begin
        higher_ius[i] = higher_ius[i-1] | ius[i-1];
      end
    end
    // a source under service masks only those below it, so nesting works
    may_request = pending & ~higher_ius;
    grant = pending & chain_in[NSRC-1:0];
    ret_clear = ius & chain_in[NSRC-1:0];
  end

  // strobe edges; the io strobe falling inside a fetch is the acknowledge
  always_comb begin
    ack_edge = ~bus.io_request_n & io_n_q & ~bus.opcode_fetch_n;
    fetch_end = ~fetch_n_q & bus.opcode_fetch_n;
  end

  // event capture and freeze; arrivals during a fetch wait in a side register
  always_comb begin
    next_arrived = arrived;
    next_pending = pending;
    if (bus.opcode_fetch_n) begin
      next_pending = pending | arrived | event_i;
      next_arrived = '0;
    end else begin
      // set wins: nothing clears this while the strobe is low
      next_arrived = arrived | event_i;
    end
    if (ack_edge) begin
      next_pending = next_pending & ~grant;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      arrived <= '0;
      pending <= '0;
    end else if (ce_i) begin
      arrived <= next_arrived;
      pending <= next_pending;
    end
  end

  // opcode snoop and in-service latches
  always_comb begin
    next_ius = ius;
    next_ack_cycle = ack_cycle;
    next_ed_seen = ed_seen;
    next_fetch_byte = fetch_byte;
    if (!bus.opcode_fetch_n && !bus.io_request_n) begin
      next_ack_cycle = 1'b1;
    end
    if (!bus.opcode_fetch_n && bus.io_request_n && !ack_cycle) begin
      next_fetch_byte = bus.bus_d;
    end
    if (ack_edge) begin
      next_ius = ius | grant;
    end
    if (fetch_end) begin
      next_ack_cycle = 1'b0;
      if (ack_cycle) begin
        next_ed_seen = 1'b0;
      end else begin
        // only the byte right after the first one counts
        next_ed_seen = (fetch_byte == DCI_OP_RET_FIRST);
        if (ed_seen && fetch_byte == DCI_OP_RET_SECOND) begin
          next_ius = ius & ~ret_clear;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ius <= '0;
      ack_cycle <= 1'b0;
      ed_seen <= 1'b0;
      fetch_byte <= 8'h00_00;
      fetch_n_q <= 1'b1;
      io_n_q <= 1'b1;
    end else if (ce_i) begin
      ius <= next_ius;
      ack_cycle <= next_ack_cycle;
      ed_seen <= next_ed_seen;
      fetch_byte <= next_fetch_byte;
      fetch_n_q <= bus.opcode_fetch_n;
      io_n_q <= bus.io_request_n;
    end
  end

  // vector register and its modified read-back
  always_comb begin
    next_vector = vector;
    if (vec_wr_i) begin
      next_vector = vec_wdata_i;
    end
    next_vec_rd = dci_mod_vec(vector, dci_first_idx(may_request));
  end

  // pin outputs, all registered; priority out trails its input by one clock
  always_comb begin
    next_int_n = ~|may_request;
    next_prio_out = chain_in[NSRC];
    next_dout = dout;
    next_dout_oe = dout_oe;
    if (ack_edge && |grant) begin
      next_dout = dci_mod_vec(vector, dci_first_idx(grant));
      next_dout_oe = 1'b1;
    end else if (bus.io_request_n || bus.opcode_fetch_n) begin
      next_dout_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vector <= DCI_VEC_RESET;
      vec_rd <= DCI_VEC_RESET;
      int_n <= 1'b1;
      prio_out <= 1'b0;
      dout <= 8'h00_00;
      dout_oe <= 1'b0;
    end else if (ce_i) begin
      vector <= next_vector;
      vec_rd <= next_vec_rd;
      int_n <= next_int_n;
      prio_out <= next_prio_out;
      dout <= next_dout;
      dout_oe <= next_dout_oe;
    end
  end

  assign bus.int_n = int_n;
  assign bus.priority_out = prio_out;
  assign bus.dev_d = dout;
  assign bus.dev_d_oe = dout_oe;
  assign vec_rdata_o = vec_rd;
  assign in_service_o = ius;
endmodule : dci_device

// ===== inc/dci_pkg.sv
package dci_pkg;
  // two-byte return opcode, snooped on the bus during fetches
  localparam logic [7:0] DCI_OP_RET_FIRST = 8'h00_ED;
  localparam logic [7:0] DCI_OP_RET_SECOND = 8'h00_4D;
  // vector register reset value and the position of the source code inside it
  localparam logic [7:0] DCI_VEC_RESET = 8'h00_00;
  localparam int DCI_VEC_CODE_LSB = 1;
  // default number of internal sources (two channels, two kinds each)
  localparam int DCI_NSRC = 4;
  // idle value of the undriven data bus seen by both ends
  localparam logic [7:0] DCI_BUS_IDLE = 8'h00_FF;
  // host timing in clock cycles, and the bit width of the host cycle counter
  localparam int DCI_FETCH_CYCLES = 3;
  localparam int DCI_ACK_M1_CYCLES = 2;
  localparam int DCI_ACK_IO_CYCLES = 2;
  localparam int DCI_CNT_W = 3;
endpackage : dci_pkg

// ===== inc/dci_if.sv
interface dci_if;
  logic int_n;
  logic opcode_fetch_n;
  logic io_request_n;
  logic priority_in;
  logic priority_out;
  logic [7:0] host_d;
  logic host_d_oe;
  logic [7:0] dev_d;
  logic dev_d_oe;
  logic [7:0] bus_d;

  // resolved data bus level; device wins so a clash shows as host data lost
  assign bus_d = dev_d_oe ? dev_d : (host_d_oe ? host_d : dci_pkg::DCI_BUS_IDLE);

  modport dev (
    input opcode_fetch_n,
    input io_request_n,
    input priority_in,
    input bus_d,
    output int_n,
    output priority_out,
    output dev_d,
    output dev_d_oe
  );

  modport host (
    output opcode_fetch_n,
    output io_request_n,
    output priority_in,
    output host_d,
    output host_d_oe,
    input int_n,
    input priority_out,
    input bus_d
  );
endinterface : dci_if

// ===== logic/dci_host.sv
module dci_host
  import dci_pkg::*;
#(
  parameter int FETCH_CYCLES = DCI_FETCH_CYCLES,
  parameter int ACK_M1_CYCLES = DCI_ACK_M1_CYCLES,
  parameter int ACK_IO_CYCLES = DCI_ACK_IO_CYCLES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic ack_req_i,
  input wire logic fetch_req_i,
  input wire logic [7:0] fetch_byte_i,
  output logic busy_o,
  output logic [7:0] vector_o,
  output logic vector_valid_o,
  output logic irq_o,
  output logic chain_out_o,
  dci_if.host bus
);
  typedef enum logic [1:0] {
    DCI_IDLE,
    DCI_FETCH,
    DCI_ACK_M1,
    DCI_ACK_IO
  } dci_hstate_t;

  dci_hstate_t state;
  dci_hstate_t next_state;
  logic [DCI_CNT_W-1:0] cnt;
  logic [DCI_CNT_W-1:0] next_cnt;
  logic fetch_n;
  logic next_fetch_n;
  logic io_n;
  logic next_io_n;
  logic [7:0] hd;
  logic [7:0] next_hd;
  logic hd_oe;
  logic next_hd_oe;
  logic [7:0] vec;
  logic [7:0] next_vec;
  logic vec_valid;
  logic next_vec_valid;
  logic irq;
  logic chain;
  logic busy;
  logic next_busy;

  // one fetch or acknowledge at a time; acknowledge wins a tie
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_fetch_n = fetch_n;
    next_io_n = io_n;
    next_hd = hd;
    next_hd_oe = hd_oe;
    next_vec = vec;
    next_vec_valid = 1'b0;
    case (state)
      DCI_IDLE: begin
        if (ack_req_i) begin
          next_state = DCI_ACK_M1;
          next_cnt = DCI_CNT_W'(ACK_M1_CYCLES - 1);
          next_fetch_n = 1'b0;
        end else if (fetch_req_i) begin
          next_state = DCI_FETCH;
          next_cnt = DCI_CNT_W'(FETCH_CYCLES - 1);
          next_fetch_n = 1'b0;
          next_hd = fetch_byte_i;
          next_hd_oe = 1'b1;
        end
      end
      DCI_FETCH: begin
        if (cnt == '0) begin
          next_state = DCI_IDLE;
          next_fetch_n = 1'b1;
          next_hd_oe = 1'b0;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      DCI_ACK_M1: begin
        if (cnt == '0) begin
          // the delay before the io strobe lets the chain settle
          next_state = DCI_ACK_IO;
          next_cnt = DCI_CNT_W'(ACK_IO_CYCLES - 1);
          next_io_n = 1'b0;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      DCI_ACK_IO: begin
        if (cnt == '0) begin
          next_state = DCI_IDLE;
          next_fetch_n = 1'b1;
          next_io_n = 1'b1;
          next_vec = bus.bus_d;
          next_vec_valid = 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = DCI_IDLE;
      end
    endcase
    // busy is registered from the next state so it lines up with the state flop
    next_busy = (next_state != DCI_IDLE);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= DCI_IDLE;
      cnt <= '0;
      fetch_n <= 1'b1;
      io_n <= 1'b1;
      hd <= 8'h00_00;
      hd_oe <= 1'b0;
      vec <= 8'h00_00;
      vec_valid <= 1'b0;
      irq <= 1'b0;
      chain <= 1'b0;
      busy <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      cnt <= next_cnt;
      fetch_n <= next_fetch_n;
      io_n <= next_io_n;
      hd <= next_hd;
      hd_oe <= next_hd_oe;
      vec <= next_vec;
      vec_valid <= next_vec_valid;
      irq <= ~bus.int_n;
      chain <= bus.priority_out;
      busy <= next_busy;
    end
  end

  assign bus.opcode_fetch_n = fetch_n;
  assign bus.io_request_n = io_n;
  assign bus.host_d = hd;
  assign bus.host_d_oe = hd_oe;
  assign bus.priority_in = 1'b1;
  assign busy_o = busy;
  assign vector_o = vec;
  assign vector_valid_o = vec_valid;
  assign irq_o = irq;
  assign chain_out_o = chain;
endmodule : dci_host

// ===== bench/dci_chk.sv
module dci_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic int_n,
  input wire logic opcode_fetch_n,
  input wire logic io_request_n,
  input wire logic priority_in,
  input wire logic priority_out,
  input wire logic host_d_oe,
  input wire logic dev_d_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // acknowledge begins on the first io edge inside a fetch
  sequence s_ack_edge;
    $fell(io_request_n) && !opcode_fetch_n;
  endsequence
  sequence s_granted;
    s_ack_edge ##0 (priority_in && !int_n);
  endsequence

  a_ack_vector:
    assert property (s_granted |-> ##1 dev_d_oe) else $error("vector not driven");
  a_oe_stands:
    assert property (dev_d_oe && !io_request_n |-> ##1 dev_d_oe) else $error("vector cut short");
  a_oe_release:
    assert property (dev_d_oe && io_request_n |-> ##1 !dev_d_oe) else $error("bus held too long");
  a_bus_quiet:
    assert property (dev_d_oe |-> !$past(io_request_n) && !$past(opcode_fetch_n))
    else $error("bus driven outside acknowledge");
  a_vec_requested:
    assert property ($rose(dev_d_oe) |-> !$past(int_n)) else $error("vector without request");
  // int_n is a pipeline of two flops, so three low samples are needed
  a_int_frozen:
    assert property (!opcode_fetch_n && !$past(opcode_fetch_n) && !$past(opcode_fetch_n, 2)
      |-> $stable(int_n)) else $error("status moved during fetch");
  a_chain_block:
    assert property ($fell(int_n) |-> !priority_out) else $error("chain left open");
  a_io_in_fetch:
    assert property (!io_request_n |-> !opcode_fetch_n) else $error("io strobe outside fetch");
  a_io_after_fetch:
    assert property ($fell(io_request_n) |-> !$past(opcode_fetch_n)) else $error("io too early");
  a_host_quiet:
    assert property (host_d_oe |-> !opcode_fetch_n && io_request_n) else $error("host bus clash");
endmodule : dci_chk

// ===== bench/dci_tb.sv
module dci_tb
  import dci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [3:0] event_i = '0;
  logic vec_wr_i = 1'b0;
  logic [7:0] vec_wdata_i = '0;
  logic ack_req_i = 1'b0;
  logic fetch_req_i = 1'b0;
  logic [7:0] fetch_byte_i = '0;
  logic [7:0] vec_rdata_o;
  logic [3:0] in_service_o;
  logic busy_o;
  logic [7:0] vector_o;
  logic vector_valid_o;
  logic irq_o;
  logic chain_out_o;
  int miscompares = 0;
  int num_checks = 0;

  dci_if u_if ();
  dci_device #(.NSRC(4)) u_dci_device (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .event_i(event_i), .vec_wr_i(vec_wr_i), .vec_wdata_i(vec_wdata_i),
    .vec_rdata_o(vec_rdata_o), .in_service_o(in_service_o), .bus(u_if.dev));
  dci_host u_dci_host (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .ack_req_i(ack_req_i),
    .fetch_req_i(fetch_req_i), .fetch_byte_i(fetch_byte_i), .busy_o(busy_o),
    .vector_o(vector_o), .vector_valid_o(vector_valid_o), .irq_o(irq_o),
    .chain_out_o(chain_out_o), .bus(u_if.host));
  dci_chk u_dci_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .int_n(u_if.int_n),
    .opcode_fetch_n(u_if.opcode_fetch_n), .io_request_n(u_if.io_request_n),
    .priority_in(u_if.priority_in), .priority_out(u_if.priority_out),
    .host_d_oe(u_if.host_d_oe), .dev_d_oe(u_if.dev_d_oe));

  // free-running clock, 100 ns period, one net for both ends so phase cannot drift
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask : chk1

  task automatic give_verdict;
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // n edges, then look at settled values on the falling edge
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  task automatic fire(input int k);
    @(posedge clk_i);
    event_i <= 4'(1 << k);
    @(posedge clk_i);
    event_i <= '0;
    settle(2);
  endtask : fire

  // bounded wait for the host to return to idle
  task automatic idle;
    int n;
    n = 0;
    settle(1);
    while (busy_o !== 1'b0 && n < 40) begin
      settle(0);
      n++;
    end
    settle(2);
  endtask : idle

  task automatic fetch(input logic [7:0] b);
    @(posedge clk_i);
    fetch_req_i <= 1'b1;
    fetch_byte_i <= b;
    @(posedge clk_i);
    fetch_req_i <= 1'b0;
    idle();
  endtask : fetch

  task automatic ack(input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge clk_i);
    ack_req_i <= 1'b1;
    @(posedge clk_i);
    ack_req_i <= 1'b0;
    while (vector_valid_o !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    chk1("vector_valid", 1'b1, vector_valid_o);
    chk("vector", exp, vector_o);
    idle();
  endtask : ack

  // a full return opcode pair, then the in-service latches
  task automatic ret(input logic [3:0] exp);
    fetch(DCI_OP_RET_FIRST);
    fetch(DCI_OP_RET_SECOND);
    chk("in_service", {4'h0, exp}, {4'h0, in_service_o});
  endtask : ret

  // a hang counts as a failure
  initial begin
    repeat (4000) @(posedge clk_i);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    settle(2);
    chk1("int_n", 1'b1, u_if.int_n);
    chk1("priority_out", 1'b1, u_if.priority_out);
    chk1("irq", 1'b0, irq_o);
    chk1("chain_out", 1'b1, chain_out_o);
    chk("vec_rdata", 8'h00_06, vec_rdata_o);
    @(posedge clk_i);
    vec_wr_i <= 1'b1;
    vec_wdata_i <= 8'h00_A0;
    @(posedge clk_i);
    vec_wr_i <= 1'b0;
    settle(1);
    chk("vec_rdata", 8'h00_A6, vec_rdata_o);
    ack(DCI_BUS_IDLE);
    fire(2);
    chk1("int_n", 1'b0, u_if.int_n);
    chk1("priority_out", 1'b0, u_if.priority_out);
    chk1("irq", 1'b1, irq_o);
    chk1("chain_out", 1'b0, chain_out_o);
    chk("vec_rdata", 8'h00_A4, vec_rdata_o);
    ack(8'h00_A4);
    chk("in_service", 8'h00_04, {4'h0, in_service_o});
    chk1("int_n", 1'b1, u_if.int_n);
    chk1("priority_out", 1'b0, u_if.priority_out);
    // lower source is held back, higher one nests
    fire(3);
    chk1("int_n", 1'b1, u_if.int_n);
    fire(0);
    chk1("int_n", 1'b0, u_if.int_n);
    ack(8'h00_A0);
    fetch(DCI_OP_RET_FIRST);
    fetch(8'h00_00);
    fetch(DCI_OP_RET_SECOND);
    chk("in_service", 8'h00_05, {4'h0, in_service_o});
    ret(4'h1 << 2);
    ret(4'h0);
    chk1("int_n", 1'b0, u_if.int_n);
    chk1("priority_out", 1'b0, u_if.priority_out);
    fetch(DCI_OP_RET_FIRST);
    chk1("priority_out", 1'b1, u_if.priority_out);
    fetch(8'h00_00);
    chk1("priority_out", 1'b0, u_if.priority_out);
    ack(8'h00_A6);
    ret(4'h0);
    chk1("priority_out", 1'b1, u_if.priority_out);
    // an event inside a fetch waits until the strobe is released
    @(posedge clk_i);
    fetch_req_i <= 1'b1;
    fetch_byte_i <= 8'h00_00;
    @(posedge clk_i);
    fetch_req_i <= 1'b0;
    event_i <= 4'h2;
    @(posedge clk_i);
    event_i <= '0;
    settle(1);
    chk1("int_n", 1'b1, u_if.int_n);
    idle();
    settle(4);
    chk1("int_n", 1'b0, u_if.int_n);
    ack(8'h00_A2);
    ret(4'h0);
    // a low clock enable freezes both ends, so a pulse then is never taken
    @(posedge clk_i);
    ce_i <= 1'b0;
    fire(1);
    chk1("int_n", 1'b1, u_if.int_n);
    @(posedge clk_i);
    ce_i <= 1'b1;
    settle(2);
    chk1("int_n", 1'b1, u_if.int_n);
    give_verdict();
  end
endmodule : dci_tb
